// file: heater_params.svh
`ifndef HEATER_PARAMS_SVH
`define HEATER_PARAMS_SVH
// register byte offsets
`define HTR_OFF_CTRL      12'h000
`define HTR_OFF_SETPOINT  12'h004
`define HTR_OFF_DEADBAND  12'h008
`define HTR_OFF_LOWTEMP   12'h00C
`define HTR_OFF_HIGHTEMP  12'h010
`define HTR_OFF_LOWCUR    12'h014
`define HTR_OFF_LOWCURB   12'h018
`define HTR_OFF_HIGHCUR   12'h01C
`define HTR_OFF_STATUS    12'h020
`define HTR_OFF_MEASURE   12'h024
// ctrl fields
`define HTR_CTRL_ENABLE   0
`define HTR_CTRL_PROP     1
`define HTR_CTRL_LIMIT    2
`define HTR_CTRL_THREEPH  3
// setpoint encoding: signed degrees, two special codes
`define HTR_SP_NONE       16'h7FFE
`define HTR_SP_OFF        16'h7FFF
// current thresholds in 0.5 A steps, zero means off
`define HTR_CUR_OFF       10'h000
// reset values
`define HTR_RST_CTRL      4'h1
`define HTR_RST_SETPOINT  16'h0014
`define HTR_RST_DEADBAND  16'h0002
`define HTR_RST_LOWTEMP   16'h0005
`define HTR_RST_HIGHTEMP  16'h7FFF
`define HTR_DUTY_FULL     7'h64
`endif

// file: heater_pkg.sv
package heater_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} busPhase_t;
  typedef struct packed {
    logic hi;
    logic lo;
  } curAlarm_t;
endpackage

// file: current_alarm.sv
`timescale 1ns/1ps
`include "heater_params.svh"
module current_alarm (
  // clock
  input  wire logic       mclk,
  input  wire logic       rst,
  // inputs
  input  wire logic [9:0] current,
  input  wire logic [9:0] lowThr,
  input  wire logic [9:0] highThr,
  input  wire logic       fullDuty,
  // alarms
  output heater_pkg::curAlarm_t alarms
);
  typedef struct packed {
    heater_pkg::curAlarm_t al;
  } state_t;
  state_t stateReg, stateNext;
  always_comb begin
    stateNext = stateReg;
    // at or below sets, strictly above releases
    stateNext.al.lo = (lowThr != `HTR_CUR_OFF) && (current <= lowThr);
    // high alarm suppressed below full duty
    stateNext.al.hi = (highThr != `HTR_CUR_OFF) && fullDuty && (current >= highThr);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end
  assign alarms = stateReg.al;
endmodule

// file: heater_setpoint_alarm_logic.sv
`timescale 1ns/1ps
`include "heater_params.svh"
// What this block does
// - setpoints written by keypad, serial port, or supervisory host over that port.
// - keypad writes accepted only while program-enable switch is on.
// - serial port writes accepted regardless of program-enable switch.
// - disabled heater blocks writes to all its other setpoints.
// - on-off control with deadband hysteresis around setpoint.
// - setpoint none keeps heater on monitored; off keeps heater on unmonitored.
// - low temperature alarm when temperature at or below threshold.
// - high temperature alarm when temperature at or above threshold.
// - temperature alarm threshold off disables; needs setpoint not off.
// - low current alarm at or below threshold, clears above; 0.5 A steps.
// - low current threshold below high, not enforced: any pair of thresholds is accepted; off disables, off by default.
// - currents scaled to full power under proportional or limit control.
// - phase B low current alarm on three-phase panels, same behaviour.
// - high current alarm at or above threshold, suppressed below full duty under proportional or limit control.
module heater_setpoint_alarm_logic (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave (serial port host)
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // keypad write port
  input  wire logic        keyWrite,
  input  wire logic [11:0] keyAddr,
  input  wire logic [15:0] keyData,
  input  wire logic        progEnable,
  // measurements
  input  wire logic [15:0] controlTemp,
  input  wire logic [9:0]  heaterCurrent,
  input  wire logic [9:0]  phaseBCurrent,
  input  wire logic [6:0]  dutyPercent,
  // outputs
  output logic             heaterOn,
  output logic             monitorOn,
  output logic             lowTempAlarm,
  output logic             highTempAlarm,
  output logic             lowCurAlarm,
  output logic             lowCurBAlarm,
  output logic             highCurAlarm
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [15:0] setpoint;
    logic [15:0] deadband;
    logic [15:0] lowTemp;
    logic [15:0] highTemp;
    logic [9:0]  lowCur;
    logic [9:0]  lowCurB;
    logic [9:0]  highCur;
    logic        busWr;
    logic [11:0] busAddr;
    logic [31:0] rdata;
    logic        heat;
    logic        mon;
    logic        loT;
    logic        hiT;
    logic [2:0]  pe;
    logic        peOk;
    logic        keyRejected;
  } state_t;
  state_t stateReg, stateNext;
  heater_pkg::curAlarm_t alA, alB;
  logic [9:0] scaledA, scaledB;
  logic       fullDuty;

  // full-power equivalent of an averaged current, I*100/duty; saturates at full scale
  function automatic logic [9:0] scale_cur(input logic [9:0] cur, input logic [6:0] duty,
                                           input logic en);
    logic [16:0] prod;
    logic [16:0] q;
    prod = 17'(cur) * 17'd100;
    q = (duty == 7'h00) ? 17'h003FF : prod / 17'(duty);
    if (!en) begin
      scale_cur = cur;
    end else if (q > 17'h003FF) begin
      scale_cur = 10'h3FF;
    end else begin
      scale_cur = q[9:0];
    end
  endfunction

  // one write path for both sources; returns next state after applying it
  function automatic state_t apply_write(input state_t s, input logic [11:0] a,
                                         input logic [15:0] d);
    state_t r;
    r = s;
    if (a == `HTR_OFF_CTRL) begin
      r.ctrl = d[3:0];
    end else if (s.ctrl[`HTR_CTRL_ENABLE]) begin
      case (a)
        `HTR_OFF_SETPOINT: r.setpoint = d;
        `HTR_OFF_DEADBAND: r.deadband = d;
        `HTR_OFF_LOWTEMP:  if (s.setpoint != `HTR_SP_OFF) r.lowTemp = d;
        `HTR_OFF_HIGHTEMP: if (s.setpoint != `HTR_SP_OFF) r.highTemp = d;
        `HTR_OFF_LOWCUR:   r.lowCur = d[9:0];
        `HTR_OFF_LOWCURB:  r.lowCurB = d[9:0];
        `HTR_OFF_HIGHCUR:  r.highCur = d[9:0];
        default:           r = s;
      endcase
    end
    apply_write = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // current-alarm comparators
  logic propOrLimit;
  assign propOrLimit = stateReg.ctrl[`HTR_CTRL_PROP] | stateReg.ctrl[`HTR_CTRL_LIMIT];
  assign scaledA = scale_cur(heaterCurrent, dutyPercent, propOrLimit);
  assign scaledB = scale_cur(phaseBCurrent, dutyPercent, propOrLimit);
  assign fullDuty = !propOrLimit || (dutyPercent >= `HTR_DUTY_FULL);

  current_alarm phaseA (
    .mclk    (mclk),
    .rst     (rst),
    .current (scaledA),
    .lowThr  (stateReg.lowCur),
    .highThr (stateReg.highCur),
    .fullDuty(fullDuty),
    .alarms  (alA)
  );
  current_alarm phaseB (
    .mclk    (mclk),
    .rst     (rst),
    .current (scaledB),
    .lowThr  (stateReg.ctrl[`HTR_CTRL_THREEPH] ? stateReg.lowCurB : `HTR_CUR_OFF),
    .highThr (`HTR_CUR_OFF),
    .fullDuty(fullDuty),
    .alarms  (alB)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic signed [16:0] tmp, spv, dbv, lov, hiv;
  logic               spSpecial;
  always_comb begin
    tmp = 17'(signed'(controlTemp));
    spv = 17'(signed'(stateReg.setpoint));
    dbv = 17'(signed'(stateReg.deadband));
    lov = 17'(signed'(stateReg.lowTemp));
    hiv = 17'(signed'(stateReg.highTemp));
    spSpecial = (stateReg.setpoint == `HTR_SP_NONE) || (stateReg.setpoint == `HTR_SP_OFF);
    stateNext = stateReg;
    // pin synchroniser, change counted when stages two and three agree
    stateNext.pe = {stateReg.pe[1:0], progEnable};
    if (stateReg.pe[2] == stateReg.pe[1]) begin
      stateNext.peOk = stateReg.pe[2];
    end
    // bus address phase, write lands in data phase
    stateNext.busWr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      stateNext.busWr = hwrite;
      stateNext.busAddr = haddr;
      case (haddr)
        `HTR_OFF_CTRL:     stateNext.rdata = {28'h0000000, stateReg.ctrl};
        `HTR_OFF_SETPOINT: stateNext.rdata = {16'h0000, stateReg.setpoint};
        `HTR_OFF_DEADBAND: stateNext.rdata = {16'h0000, stateReg.deadband};
        `HTR_OFF_LOWTEMP:  stateNext.rdata = {16'h0000, stateReg.lowTemp};
        `HTR_OFF_HIGHTEMP: stateNext.rdata = {16'h0000, stateReg.highTemp};
        `HTR_OFF_LOWCUR:   stateNext.rdata = {22'h000000, stateReg.lowCur};
        `HTR_OFF_LOWCURB:  stateNext.rdata = {22'h000000, stateReg.lowCurB};
        `HTR_OFF_HIGHCUR:  stateNext.rdata = {22'h000000, stateReg.highCur};
        `HTR_OFF_STATUS:   stateNext.rdata = {24'h000000, stateReg.keyRejected, alA.hi,
                                              alB.lo, alA.lo, stateReg.hiT, stateReg.loT,
                                              stateReg.mon, stateReg.heat};
        `HTR_OFF_MEASURE:  stateNext.rdata = {6'h00, heaterCurrent, controlTemp};
        default:           stateNext.rdata = 32'h00000000;
      endcase
    end
    // bus writes ignore the switch; keypad waits on it; bus wins a collision
    if (stateReg.busWr) begin
      stateNext = apply_write(stateNext, stateReg.busAddr, hwdata[15:0]);
    end else if (keyWrite && stateReg.peOk) begin
      stateNext = apply_write(stateNext, keyAddr, keyData);
    end
    if (keyWrite && !stateReg.peOk) begin
      stateNext.keyRejected = 1'b1;
    end else if (stateReg.busWr && stateReg.busAddr == `HTR_OFF_STATUS) begin
      stateNext.keyRejected = 1'b0;
    end
    // control and temperature alarms
    if (!stateReg.ctrl[`HTR_CTRL_ENABLE]) begin
      stateNext.heat = 1'b0;
      stateNext.mon = 1'b0;
      stateNext.loT = 1'b0;
      stateNext.hiT = 1'b0;
    end else begin
      if (stateReg.setpoint == `HTR_SP_OFF) begin
        stateNext.heat = 1'b1;
        stateNext.mon = 1'b0;
      end else if (stateReg.setpoint == `HTR_SP_NONE) begin
        stateNext.heat = 1'b1;
        stateNext.mon = 1'b1;
      end else begin
        stateNext.mon = 1'b1;
        if (tmp < spv - dbv) begin
          stateNext.heat = 1'b1;
        end else if (tmp > spv + dbv) begin
          stateNext.heat = 1'b0;
        end
      end
      // recrossing the threshold releases the alarm
      stateNext.loT = (stateReg.setpoint != `HTR_SP_OFF) && (stateReg.lowTemp != `HTR_SP_OFF)
                      && (tmp <= lov);
      stateNext.hiT = (stateReg.setpoint != `HTR_SP_OFF) && (stateReg.highTemp != `HTR_SP_OFF)
                      && (tmp >= hiv);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stateReg <= '0;
      stateReg.ctrl <= `HTR_RST_CTRL;
      stateReg.setpoint <= `HTR_RST_SETPOINT;
      stateReg.deadband <= `HTR_RST_DEADBAND;
      stateReg.lowTemp <= `HTR_RST_LOWTEMP;
      stateReg.highTemp <= `HTR_RST_HIGHTEMP;
      stateReg.lowCur <= `HTR_CUR_OFF;
      stateReg.highCur <= `HTR_CUR_OFF;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero wait states, always okay
  assign hrdata = stateReg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign heaterOn = stateReg.heat;
  assign monitorOn = stateReg.mon;
  assign lowTempAlarm = stateReg.loT;
  assign highTempAlarm = stateReg.hiT;
  assign lowCurAlarm = alA.lo;
  assign lowCurBAlarm = alB.lo;
  assign highCurAlarm = alA.hi;

  ////////////////////////////////////////////////////////////////////////////
  chk_key_blocked: assert property (@(posedge mclk) disable iff (rst)
    (keyWrite && !stateReg.peOk && !stateReg.busWr) |=> $stable(stateReg.setpoint))
    else $error("keypad write landed while disabled");
  chk_bus_write: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.busWr && stateReg.busAddr == `HTR_OFF_SETPOINT && stateReg.ctrl[0])
    |=> stateReg.setpoint == $past(hwdata[15:0]))
    else $error("bus setpoint write lost");
  chk_disabled_lock: assert property (@(posedge mclk) disable iff (rst)
    !stateReg.ctrl[0] |=> $stable(stateReg.deadband))
    else $error("disabled heater setpoint changed");
  chk_heat_on: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[0] && !spSpecial && tmp < spv - dbv) |=> heaterOn)
    else $error("heater not energised below band");
  chk_heat_off: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[0] && !spSpecial && tmp > spv + dbv) |=> !heaterOn)
    else $error("heater not released above band");
  chk_sp_special: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[0] && stateReg.setpoint == `HTR_SP_OFF) |=> heaterOn && !monitorOn)
    else $error("setpoint off handling wrong");
  chk_low_temp: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[0] && stateReg.setpoint != `HTR_SP_OFF && stateReg.lowTemp != `HTR_SP_OFF)
    |=> lowTempAlarm == ($past(tmp) <= $past(lov)))
    else $error("low temperature alarm mismatch");
  chk_high_temp: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[0] && stateReg.setpoint != `HTR_SP_OFF && stateReg.highTemp != `HTR_SP_OFF)
    |=> highTempAlarm == ($past(tmp) >= $past(hiv)))
    else $error("high temperature alarm mismatch");
  chk_low_cur: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.lowCur != 10'h000) |=> lowCurAlarm == ($past(scaledA) <= $past(stateReg.lowCur)))
    else $error("low current alarm mismatch");
  chk_high_sup: assert property (@(posedge mclk) disable iff (rst)
    !fullDuty |=> !highCurAlarm)
    else $error("high current alarm not suppressed");
  chk_high_cur: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.highCur != `HTR_CUR_OFF && fullDuty && scaledA >= stateReg.highCur)
    |=> highCurAlarm)
    else $error("high current alarm missed");
  chk_low_cur_b: assert property (@(posedge mclk) disable iff (rst)
    (stateReg.ctrl[`HTR_CTRL_THREEPH] && stateReg.lowCurB != `HTR_CUR_OFF)
    |=> lowCurBAlarm == ($past(scaledB) <= $past(stateReg.lowCurB)))
    else $error("phase b low current alarm mismatch");
  chk_single_b: assert property (@(posedge mclk) disable iff (rst)
    !stateReg.ctrl[`HTR_CTRL_THREEPH] |=> !lowCurBAlarm)
    else $error("phase b alarm on single-phase panel");
  chk_key_taken: assert property (@(posedge mclk) disable iff (rst)
    (keyWrite && stateReg.peOk && !stateReg.busWr && stateReg.ctrl[`HTR_CTRL_ENABLE]
     && keyAddr == `HTR_OFF_DEADBAND) |=> stateReg.deadband == $past(keyData))
    else $error("enabled keypad write lost");
  chk_disabled_out: assert property (@(posedge mclk) disable iff (rst)
    !stateReg.ctrl[`HTR_CTRL_ENABLE] |=> !heaterOn && !monitorOn)
    else $error("disabled heater still driven");
  chk_low_clear: assert property (@(posedge mclk) disable iff (rst)
    (tmp > lov) |=> !lowTempAlarm)
    else $error("low temperature alarm not released");
  cov_heat_cycle: cover property (@(posedge mclk) disable iff (rst) heaterOn ##[1:50] !heaterOn);
  cov_key_reject: cover property (@(posedge mclk) disable iff (rst) keyWrite && !stateReg.peOk);
  cov_low_cur: cover property (@(posedge mclk) disable iff (rst) lowCurAlarm);
  cov_key_taken: cover property (@(posedge mclk) disable iff (rst) keyWrite && stateReg.peOk);
endmodule

// file: keypad_model.sv
`timescale 1ns/1ps
module keypad_model (
  // clock
  input  wire logic        mclk,
  // keypad and switch
  output logic             keyWrite,
  output logic      [11:0] keyAddr,
  output logic      [15:0] keyData,
  output logic             progEnable
);
  initial begin
    keyWrite   = 1'b0;
    keyAddr    = 12'h000;
    keyData    = 16'h0000;
    progEnable = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // lines go to the inverse after the strobe so stale data never looks valid
  task automatic press(input logic [11:0] a, input logic [15:0] d);
    keyAddr  <= a;
    keyData  <= d;
    keyWrite <= 1'b1;
    @(posedge mclk);
    keyWrite <= 1'b0;
    keyAddr  <= ~a;
    keyData  <= ~d;
  endtask
  task automatic setSwitch(input logic on);
    progEnable <= on;
  endtask
endmodule

// file: heater_setpoint_alarm_logic_tb_top.sv
`timescale 1ns/1ps
`include "heater_params.svh"
module heater_setpoint_alarm_logic_tb_top;
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp, keyWrite, progEnable;
  logic [11:0] haddr, keyAddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic [15:0] keyData, controlTemp;
  logic [9:0]  heaterCurrent, phaseBCurrent;
  logic [6:0]  dutyPercent;
  logic        heaterOn, monitorOn, lowTempAlarm, highTempAlarm;
  logic        lowCurAlarm, lowCurBAlarm, highCurAlarm;
  int          errCount, checks;
  heater_setpoint_alarm_logic i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .keyWrite(keyWrite),
    .keyAddr(keyAddr), .keyData(keyData), .progEnable(progEnable),
    .controlTemp(controlTemp), .heaterCurrent(heaterCurrent),
    .phaseBCurrent(phaseBCurrent), .dutyPercent(dutyPercent), .heaterOn(heaterOn),
    .monitorOn(monitorOn), .lowTempAlarm(lowTempAlarm), .highTempAlarm(highTempAlarm),
    .lowCurAlarm(lowCurAlarm), .lowCurBAlarm(lowCurBAlarm), .highCurAlarm(highCurAlarm));
  keypad_model i_key (.mclk(mclk), .keyWrite(keyWrite), .keyAddr(keyAddr),
    .keyData(keyData), .progEnable(progEnable));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errCount, checks);
    if (errCount == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, rv, e);
    chk("resp", {31'h0, hresp}, 32'h0);
  endtask
  // outputs settle one cycle after inputs, registered current alarms in the same one cycle
  task automatic ms(input logic [15:0] t, input logic [9:0] c, input logic [9:0] cb,
                    input logic [6:0] d);
    controlTemp   <= t;
    heaterCurrent <= c;
    phaseBCurrent <= cb;
    dutyPercent   <= d;
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    errCount++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; controlTemp = 16'h0014; heaterCurrent = 10'h000;
    phaseBCurrent = 10'h000; dutyPercent = 7'h64; errCount = 0; checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk("ctrl", `HTR_OFF_CTRL, 32'h1);
    rchk("setp", `HTR_OFF_SETPOINT, 32'h14);
    rchk("dband", `HTR_OFF_DEADBAND, 32'h2);
    rchk("lowt", `HTR_OFF_LOWTEMP, 32'h5);
    rchk("hight", `HTR_OFF_HIGHTEMP, 32'h7FFF);
    rchk("lowc", `HTR_OFF_LOWCUR, 32'h0);
    rchk("unmap", 12'h040, 32'h0);
    // deadband edges: 18 and 22 hold, 17 and 23 switch
    ms(16'h000A, 10'h000, 10'h000, 7'h64); chk("on10", heaterOn, 32'h1);
    ms(16'h0016, 10'h000, 10'h000, 7'h64); chk("hold22", heaterOn, 32'h1);
    ms(16'h0017, 10'h000, 10'h000, 7'h64); chk("off23", heaterOn, 32'h0);
    ms(16'h0012, 10'h000, 10'h000, 7'h64); chk("hold18", heaterOn, 32'h0);
    ms(16'h0011, 10'h000, 10'h000, 7'h64); chk("on17", heaterOn, 32'h1);
    ms(16'h0005, 10'h000, 10'h000, 7'h64); chk("lowt5", lowTempAlarm, 32'h1);
    ms(16'h0006, 10'h000, 10'h000, 7'h64); chk("lowt6", lowTempAlarm, 32'h0);
    wr(`HTR_OFF_HIGHTEMP, 32'h1E);
    ms(16'h001E, 10'h000, 10'h000, 7'h64); chk("hit30", highTempAlarm, 32'h1);
    ms(16'h001D, 10'h000, 10'h000, 7'h64); chk("hit29", highTempAlarm, 32'h0);
    wr(`HTR_OFF_HIGHTEMP, 32'h7FFF);
    ms(16'h0028, 10'h000, 10'h000, 7'h64); chk("hitoff", highTempAlarm, 32'h0);
    wr(`HTR_OFF_SETPOINT, 32'h7FFE);
    repeat (3) @(posedge mclk);
    chk("noneh", heaterOn, 32'h1);
    chk("nonem", monitorOn, 32'h1);
    wr(`HTR_OFF_SETPOINT, 32'h7FFF);
    repeat (3) @(posedge mclk);
    chk("offh", heaterOn, 32'h1);
    chk("offm", monitorOn, 32'h0);
    wr(`HTR_OFF_LOWTEMP, 32'h32);
    rchk("lowtlock", `HTR_OFF_LOWTEMP, 32'h5);
    wr(`HTR_OFF_SETPOINT, 32'h14);
    // keypad refused while switch open, taken once it has synced
    i_key.press(`HTR_OFF_DEADBAND, 16'h0007);
    repeat (2) @(posedge mclk);
    rchk("keyoff", `HTR_OFF_DEADBAND, 32'h2);
    xfer(1'b0, `HTR_OFF_STATUS, 32'h0);
    chk("rej", rv[7], 32'h1);
    wr(`HTR_OFF_STATUS, 32'h0);
    xfer(1'b0, `HTR_OFF_STATUS, 32'h0);
    chk("rejclr", rv[7], 32'h0);
    i_key.setSwitch(1'b1);
    repeat (8) @(posedge mclk);
    i_key.press(`HTR_OFF_DEADBAND, 16'h0007);
    repeat (2) @(posedge mclk);
    rchk("keyon", `HTR_OFF_DEADBAND, 32'h7);
    i_key.setSwitch(1'b0);
    repeat (8) @(posedge mclk);
    wr(`HTR_OFF_DEADBAND, 32'h3);
    rchk("busw", `HTR_OFF_DEADBAND, 32'h3);
    wr(`HTR_OFF_LOWCUR, 32'hA);
    wr(`HTR_OFF_HIGHCUR, 32'h14);
    ms(16'h0014, 10'h00A, 10'h000, 7'h64); chk("loc10", lowCurAlarm, 32'h1);
    ms(16'h0014, 10'h00B, 10'h000, 7'h64); chk("loc11", lowCurAlarm, 32'h0);
    ms(16'h0014, 10'h014, 10'h000, 7'h64); chk("hic20", highCurAlarm, 32'h1);
    ms(16'h0014, 10'h013, 10'h000, 7'h64); chk("hic19", highCurAlarm, 32'h0);
    // half duty doubles the compared current
    wr(`HTR_OFF_CTRL, 32'h3);
    ms(16'h0014, 10'h005, 10'h000, 7'h32); chk("scl5", lowCurAlarm, 32'h1);
    ms(16'h0014, 10'h006, 10'h000, 7'h32); chk("scl6", lowCurAlarm, 32'h0);
    ms(16'h0014, 10'h00A, 10'h000, 7'h32); chk("hisup", highCurAlarm, 32'h0);
    wr(`HTR_OFF_CTRL, 32'h5);
    ms(16'h0014, 10'h005, 10'h000, 7'h32);
    chk("lim5", lowCurAlarm, 32'h1);
    wr(`HTR_OFF_CTRL, 32'h9);
    wr(`HTR_OFF_LOWCURB, 32'h8);
    ms(16'h0014, 10'h00F, 10'h008, 7'h64); chk("locb8", lowCurBAlarm, 32'h1);
    xfer(1'b0, `HTR_OFF_STATUS, 32'h0);
    chk("statb", rv[5], 32'h1);
    ms(16'h0014, 10'h00F, 10'h009, 7'h64); chk("locb9", lowCurBAlarm, 32'h0);
    wr(`HTR_OFF_CTRL, 32'h0);
    wr(`HTR_OFF_SETPOINT, 32'h30);
    rchk("dislock", `HTR_OFF_SETPOINT, 32'h14);
    ms(16'h000A, 10'h000, 10'h000, 7'h64); chk("disoff", heaterOn, 32'h0);
    tally_and_finish();
  end
endmodule
